// *** rtl/lrw_addr_top.sv ***
// Display RAM write addressing, cascade subaddressing and bank selection.
// Assumes an Avalon-MM master on MCLK and strapped subaddress pins.
// Behaviour
// - A pointer load sets where the first display byte lands.
// - Pointer advances 8, 4, 3 or 2 per byte by drive mode.
// - A byte is stored only where the counter, or past the last address the counter plus one, equals the strapped subaddress.
// - A subaddress command loads the cascade counter.
// - Mismatched bytes are dropped but the pointer still advances.
// - Pointer overflow past the last address increments the counter.
// - Bits beyond the last address go to the next cascaded device.
// - Output bank picks one of four rows per address for display.
// - Display row cycles through the rows the drive mode uses.
// - Static mode with alternate bank displays row 2.
// - 1:2 mode with alternate bank displays rows 2 and 3.
// - Input bank steers writes into rows 2 or 2 and 3.
// - Input and output bank settings are independent states.
// - Alternate-bank blink swaps the displayed bank at blink rate.
// - Only the matching device acknowledges display bytes.
// - A command byte with MSB clear ends commands; data follows.
//
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module lrw_addr_top
	import lrw_pkg::*;
#(
	parameter int BLINK_CYC = BLINK_HALF_CYC,
	parameter int PHASE_TICK_CYC = PHASE_CYC
) (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic [4:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic HW_SUBADDR_BIT0,
	input wire logic HW_SUBADDR_BIT1,
	input wire logic HW_SUBADDR_BIT2,
	output logic [RAM_ADDRS-1:0] DISP_DATA,
	output logic [1:0] DISP_ROW,
	output logic DATA_ACK
);
	if (BLINK_CYC < 2 || PHASE_TICK_CYC < 2) begin : g_bad_div
		$error("Divider counts must be at least 2");
	end

	lrw_ram_if rif ();
	lrw_ram u_ram (.MCLK(MCLK), .RST_N(RST_N), .rif(rif));

	// Bus slave: one wait cycle, then the access completes
	logic ack_ff, nxt_ack;
	logic [31:0] rdata_ff, nxt_rdata;
	logic req, acc_wr, lo_wr;
	assign req = AVS_READ | AVS_WRITE;
	assign AVS_WAITREQUEST = req & ~ack_ff;
	assign AVS_READDATA = rdata_ff;
	assign acc_wr = AVS_WRITE & ack_ff;
	assign lo_wr = acc_wr & AVS_BYTEENABLE[0];

	// Strap pins: three stages, accepted when stages two and three agree
	logic [2:0] s1_ff, s2_ff, s3_ff, hw_ff, nxt_hw;
	always_comb begin
		nxt_hw = hw_ff;
		if (s2_ff == s3_ff) begin
			nxt_hw = s3_ff;
		end
	end
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			s1_ff <= 3'h0;
			s2_ff <= 3'h0;
			s3_ff <= 3'h0;
			hw_ff <= 3'h0;
		end else begin
			s1_ff <= {HW_SUBADDR_BIT2, HW_SUBADDR_BIT1, HW_SUBADDR_BIT0};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			hw_ff <= nxt_hw;
		end
	end

	// Control and addressing state
	lrw_mode_t mode_ff, nxt_mode;
	logic ibank_ff, nxt_ibank, obank_ff, nxt_obank, blink_en_ff, nxt_blink_en;
	logic [5:0] ptr_ff, nxt_ptr;
	logic [2:0] cnt_ff, nxt_cnt;
	logic cmd_ff, nxt_cmd, dack_ff, nxt_dack;
	logic data_wr;
	logic [6:0] ptr_sum;
	logic [1:0] row_base;

	assign data_wr = lo_wr && AVS_ADDRESS == OFS_STREAM && !cmd_ff;
	assign ptr_sum = {1'b0, ptr_ff} + {3'h0, mode_step(mode_ff)};
	assign row_base = (ibank_ff && mode_banked(mode_ff)) ? 2'h2 : 2'h0;

	always_comb begin
		nxt_mode = mode_ff;
		nxt_ibank = ibank_ff;
		nxt_obank = obank_ff;
		nxt_blink_en = blink_en_ff;
		nxt_ptr = ptr_ff;
		nxt_cnt = cnt_ff;
		nxt_cmd = cmd_ff;
		nxt_dack = dack_ff;
		nxt_ack = req & ~ack_ff;
		nxt_rdata = rdata_ff;
		if (lo_wr) begin
			unique case (AVS_ADDRESS)
				OFS_CTRL: begin
					nxt_mode = lrw_mode_t'(AVS_WRITEDATA[CTRL_MODE_LSB +: 2]);
					nxt_ibank = AVS_WRITEDATA[CTRL_IBANK_BIT];
					nxt_obank = AVS_WRITEDATA[CTRL_OBANK_BIT];
					nxt_blink_en = AVS_WRITEDATA[CTRL_BLINK_BIT];
				end
				OFS_PTR: nxt_ptr = AVS_WRITEDATA[5:0];
				OFS_SUBADDR: nxt_cnt = AVS_WRITEDATA[2:0];
				OFS_FRAME: nxt_cmd = 1'b1;
				OFS_STREAM: begin
					if (cmd_ff && !AVS_WRITEDATA[STREAM_CONT_BIT]) begin
						nxt_cmd = 1'b0;
					end
				end
				default: ;
			endcase
		end
		if (data_wr) begin
			nxt_dack = (cnt_ff == hw_ff);
			if (ptr_sum >= ADDR_COUNT) begin
				nxt_ptr = 6'(ptr_sum - ADDR_COUNT);
				nxt_cnt = cnt_ff + 3'h1;
			end else begin
				nxt_ptr = ptr_sum[5:0];
			end
		end
		if (req && !ack_ff) begin
			nxt_rdata = 32'h0000_0000;
			unique case (AVS_ADDRESS)
				OFS_CTRL: nxt_rdata[4:0] = {blink_en_ff, obank_ff, ibank_ff, mode_ff};
				OFS_PTR: nxt_rdata[5:0] = ptr_ff;
				OFS_SUBADDR: nxt_rdata[2:0] = cnt_ff;
				OFS_STATUS: begin
					nxt_rdata[STAT_CMD_BIT] = cmd_ff;
					nxt_rdata[STAT_ACK_BIT] = dack_ff;
					nxt_rdata[STAT_HW_LSB +: 3] = hw_ff;
					nxt_rdata[STAT_MATCH_BIT] = (cnt_ff == hw_ff);
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			mode_ff <= lrw_mode_t'(MODE_RST);
			ibank_ff <= 1'b0;
			obank_ff <= 1'b0;
			blink_en_ff <= 1'b0;
			ptr_ff <= PTR_RST;
			cnt_ff <= SUBADDR_RST;
			cmd_ff <= 1'b1;
			dack_ff <= 1'b0;
			ack_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else begin
			mode_ff <= nxt_mode;
			ibank_ff <= nxt_ibank;
			obank_ff <= nxt_obank;
			blink_en_ff <= nxt_blink_en;
			ptr_ff <= nxt_ptr;
			cnt_ff <= nxt_cnt;
			cmd_ff <= nxt_cmd;
			dack_ff <= nxt_dack;
			ack_ff <= nxt_ack;
			rdata_ff <= nxt_rdata;
		end
	end
	assign DATA_ACK = dack_ff;

	// Store mask: each bit targets this device or, past the end, the next
	always_comb begin
		logic [4:0] pl;
		logic [6:0] abs_a;
		logic [2:0] tgt;
		int idx;
		pl = 5'h00;
		abs_a = 7'h00;
		tgt = 3'h0;
		idx = 0;
		rif.wr_mask = '0;
		rif.wr_val = '0;
		for (int k = 0; k < 8; k++) begin
			if (mode_ff != LRW_MODE_MUX3 || k < 8) begin
				pl = bit_place(mode_ff, k);
				abs_a = {1'b0, ptr_ff} + {4'h0, pl[4:2]};
				tgt = cnt_ff;
				if (abs_a >= ADDR_COUNT) begin
					abs_a = abs_a - ADDR_COUNT;
					tgt = cnt_ff + 3'h1;
				end
				idx = int'(row_base + pl[1:0]) * RAM_ADDRS + int'(abs_a);
				if (data_wr && tgt == hw_ff && abs_a < ADDR_COUNT) begin
					rif.wr_mask[idx] = 1'b1;
					rif.wr_val[idx] = AVS_WRITEDATA[7 - k];
				end
			end
		end
	end

	// Multiplex phase and blink dividers
	logic [$clog2(PHASE_TICK_CYC)-1:0] pdiv_ff, nxt_pdiv;
	logic [$clog2(BLINK_CYC)-1:0] bdiv_ff, nxt_bdiv;
	logic [1:0] phase_ff, nxt_phase;
	logic blink_ff, nxt_blink;
	logic [RAM_ADDRS-1:0] disp_ff;
	logic [1:0] row_ff, nxt_row;
	logic alt_sel;

	always_comb begin
		nxt_pdiv = pdiv_ff + 1'b1;
		nxt_phase = phase_ff;
		nxt_bdiv = bdiv_ff + 1'b1;
		nxt_blink = blink_ff;
		if (phase_ff > mode_last_row(mode_ff)) begin
			nxt_phase = 2'h0;
		end
		if (pdiv_ff == ($bits(pdiv_ff))'(PHASE_TICK_CYC - 1)) begin
			nxt_pdiv = '0;
			nxt_phase = (phase_ff >= mode_last_row(mode_ff)) ? 2'h0 : phase_ff + 2'h1;
		end
		if (!blink_en_ff) begin
			nxt_bdiv = '0;
			nxt_blink = 1'b0;
		end else if (bdiv_ff == ($bits(bdiv_ff))'(BLINK_CYC - 1)) begin
			nxt_bdiv = '0;
			nxt_blink = ~blink_ff;
		end
	end

	assign alt_sel = (obank_ff ^ blink_ff) && mode_banked(mode_ff);
	assign nxt_row = alt_sel ? phase_ff + 2'h2 : phase_ff;
	assign rif.rd_row = row_ff;

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			pdiv_ff <= '0;
			bdiv_ff <= '0;
			phase_ff <= 2'h0;
			blink_ff <= 1'b0;
			row_ff <= 2'h0;
			disp_ff <= '0;
		end else begin
			pdiv_ff <= nxt_pdiv;
			bdiv_ff <= nxt_bdiv;
			phase_ff <= nxt_phase;
			blink_ff <= nxt_blink;
			row_ff <= nxt_row;
			disp_ff <= rif.row_bits;
		end
	end
	assign DISP_DATA = disp_ff;
	assign DISP_ROW = row_ff;

	property p_ptr_load;
		@(posedge MCLK) disable iff (!RST_N)
		lo_wr && AVS_ADDRESS == OFS_PTR |=> ptr_ff == $past(AVS_WRITEDATA[5:0]);
	endproperty
	a_ptr_load: assert property (p_ptr_load) else $error("Pointer load lost");

	property p_step;
		@(posedge MCLK) disable iff (!RST_N)
		data_wr && ptr_sum < ADDR_COUNT |=> ptr_ff == $past(ptr_ff) + 6'(mode_step($past(mode_ff)));
	endproperty
	a_step: assert property (p_step) else $error("Pointer step wrong");

	property p_cnt_load;
		@(posedge MCLK) disable iff (!RST_N)
		lo_wr && AVS_ADDRESS == OFS_SUBADDR |=> cnt_ff == $past(AVS_WRITEDATA[2:0]);
	endproperty
	a_cnt_load: assert property (p_cnt_load) else $error("Counter load lost");

	property p_no_store;
		@(posedge MCLK) disable iff (!RST_N)
		data_wr && cnt_ff != hw_ff && ptr_sum < ADDR_COUNT |-> rif.wr_mask == '0;
	endproperty
	a_no_store: assert property (p_no_store) else $error("Stored on mismatch");

	property p_skip_adv;
		@(posedge MCLK) disable iff (!RST_N)
		data_wr && cnt_ff != hw_ff |=> ptr_ff != $past(ptr_ff) && !DATA_ACK;
	endproperty
	a_skip_adv: assert property (p_skip_adv) else $error("No advance on mismatch");

	property p_ovf;
		@(posedge MCLK) disable iff (!RST_N)
		data_wr && ptr_sum >= ADDR_COUNT |=> cnt_ff == $past(cnt_ff) + 3'h1 && ptr_ff < 6'h28;
	endproperty
	a_ovf: assert property (p_ovf) else $error("Overflow not handled");

	property p_static_row;
		@(posedge MCLK) disable iff (!RST_N)
		mode_ff == LRW_MODE_STATIC && !obank_ff && !blink_en_ff [*3] |-> DISP_ROW == 2'h0;
	endproperty
	a_static_row: assert property (p_static_row) else $error("Static row not 0");

	property p_mux2_alt;
		@(posedge MCLK) disable iff (!RST_N)
		mode_ff == LRW_MODE_MUX2 && obank_ff && !blink_en_ff && phase_ff < 2'h2 |=> DISP_ROW[1];
	endproperty
	a_mux2_alt: assert property (p_mux2_alt) else $error("Alternate bank not shown");

	property p_ibank;
		@(posedge MCLK) disable iff (!RST_N)
		data_wr && mode_ff == LRW_MODE_STATIC && ibank_ff |->
			rif.wr_mask[2*RAM_ADDRS-1:0] == '0 && rif.wr_mask[RAM_BITS-1:3*RAM_ADDRS] == '0;
	endproperty
	a_ibank: assert property (p_ibank) else $error("Input bank row wrong");

	property p_cmd_end;
		@(posedge MCLK) disable iff (!RST_N)
		lo_wr && AVS_ADDRESS == OFS_STREAM && cmd_ff && !AVS_WRITEDATA[7] |=> !cmd_ff;
	endproperty
	a_cmd_end: assert property (p_cmd_end) else $error("Command phase not ended");

	c_overflow: cover property (@(posedge MCLK) disable iff (!RST_N) data_wr && ptr_sum >= ADDR_COUNT);
	c_blink: cover property (@(posedge MCLK) disable iff (!RST_N) blink_en_ff && $rose(blink_ff));
	c_match: cover property (@(posedge MCLK) disable iff (!RST_N) data_wr && cnt_ff == hw_ff);
endmodule : lrw_addr_top
`default_nettype wire

// *** rtl/lrw_pkg.sv ***
// Constants, types and helpers of the display RAM write-addressing block.
// Assumes a single 20 MHz clock domain.
`default_nettype none
package lrw_pkg;
	localparam int RAM_ADDRS = 40;
	localparam int RAM_ROWS = 4;
	localparam int RAM_BITS = RAM_ADDRS * RAM_ROWS;
	localparam logic [6:0] ADDR_COUNT = 7'h28;

	// Byte offsets on the register bus
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_PTR = 5'h04;
	localparam logic [4:0] OFS_SUBADDR = 5'h08;
	localparam logic [4:0] OFS_STREAM = 5'h0C;
	localparam logic [4:0] OFS_FRAME = 5'h10;
	localparam logic [4:0] OFS_STATUS = 5'h14;

	// Field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_IBANK_BIT = 2;
	localparam int CTRL_OBANK_BIT = 3;
	localparam int CTRL_BLINK_BIT = 4;
	localparam int STAT_CMD_BIT = 0;
	localparam int STAT_ACK_BIT = 1;
	localparam int STAT_HW_LSB = 2;
	localparam int STAT_MATCH_BIT = 5;
	localparam int STREAM_CONT_BIT = 7;

	typedef enum logic [1:0] {
		LRW_MODE_MUX4 = 2'b00,
		LRW_MODE_STATIC = 2'b01,
		LRW_MODE_MUX2 = 2'b10,
		LRW_MODE_MUX3 = 2'b11
	} lrw_mode_t;

	// Reset values
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic [5:0] PTR_RST = 6'h00;
	localparam logic [2:0] SUBADDR_RST = 3'h0;

	// Pointer steps per mode
	localparam logic [3:0] STEP_STATIC = 4'h8;
	localparam logic [3:0] STEP_MUX2 = 4'h4;
	localparam logic [3:0] STEP_MUX3 = 4'h3;
	localparam logic [3:0] STEP_MUX4 = 4'h2;

	// Timing
	localparam int CLK_HZ = 20_000_000;
	localparam int BLINK_HALF_MS = 250;
	localparam int BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
	localparam int PHASE_US = 100;
	localparam int PHASE_CYC = CLK_HZ / 1_000_000 * PHASE_US;

	function automatic logic [3:0] mode_step(input lrw_mode_t m);
		unique case (m)
			LRW_MODE_STATIC: mode_step = STEP_STATIC;
			LRW_MODE_MUX2: mode_step = STEP_MUX2;
			LRW_MODE_MUX3: mode_step = STEP_MUX3;
			LRW_MODE_MUX4: mode_step = STEP_MUX4;
		endcase
	endfunction : mode_step

	function automatic logic [1:0] mode_last_row(input lrw_mode_t m);
		unique case (m)
			LRW_MODE_STATIC: mode_last_row = 2'h0;
			LRW_MODE_MUX2: mode_last_row = 2'h1;
			LRW_MODE_MUX3: mode_last_row = 2'h2;
			LRW_MODE_MUX4: mode_last_row = 2'h3;
		endcase
	endfunction : mode_last_row

	function automatic logic mode_banked(input lrw_mode_t m);
		mode_banked = (m == LRW_MODE_STATIC) || (m == LRW_MODE_MUX2);
	endfunction : mode_banked

	// Bit k of a byte (MSB first): {address offset, row}
	function automatic logic [4:0] bit_place(input lrw_mode_t m, input int k);
		logic [2:0] off;
		logic [1:0] row;
		off = 3'h0;
		row = 2'h0;
		unique case (m)
			LRW_MODE_STATIC: begin
				off = 3'(k);
			end
			LRW_MODE_MUX2: begin
				off = 3'(k / 2);
				row = 2'(k % 2);
			end
			LRW_MODE_MUX3: begin
				off = 3'(k / 3);
				row = 2'(k % 3);
			end
			LRW_MODE_MUX4: begin
				off = 3'(k / 4);
				row = 2'(k % 4);
			end
		endcase
		bit_place = {off, row};
	endfunction : bit_place
endpackage : lrw_pkg
`default_nettype wire

// *** rtl/lrw_ram_if.sv ***
// Write and display-read signals between addressing logic and display RAM.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface lrw_ram_if;
	import lrw_pkg::*;
	logic [RAM_BITS-1:0] wr_mask;
	logic [RAM_BITS-1:0] wr_val;
	logic [1:0] rd_row;
	logic [RAM_ADDRS-1:0] row_bits;
	modport ctl (output wr_mask, output wr_val, output rd_row, input row_bits);
	modport ram (input wr_mask, input wr_val, input rd_row, output row_bits);
endinterface : lrw_ram_if
`default_nettype wire

// *** rtl/lrw_ram.sv ***
// Display RAM of four rows per address, bit-masked write, one row read.
// Assumes a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module lrw_ram
	import lrw_pkg::*;
(
	input wire logic MCLK,
	input wire logic RST_N,
	lrw_ram_if.ram rif
);
	logic [RAM_BITS-1:0] mem_ff;
	logic [RAM_BITS-1:0] nxt_mem;

	always_comb begin
		nxt_mem = (mem_ff & ~rif.wr_mask) | (rif.wr_val & rif.wr_mask);
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			mem_ff <= '0;
		end else begin
			mem_ff <= nxt_mem;
		end
	end

	assign rif.row_bits = mem_ff[rif.rd_row * RAM_ADDRS +: RAM_ADDRS];
endmodule : lrw_ram
`default_nettype wire

// *** sim/lrw_bus_model.sv ***
// Register-bus master standing in for the serial controller.
// Assumes one clock and a slave that stalls with waitrequest.
`timescale 1ns/10ps
`default_nettype none
module lrw_bus_model
	import lrw_pkg::*;
(
	input wire logic clk,
	output logic [4:0] address,
	output logic read,
	output logic write,
	output logic [31:0] writedata,
	output logic [3:0] byteenable,
	input wire logic [31:0] readdata,
	input wire logic waitrequest
);
	initial begin
		address = 5'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0000_0000;
		byteenable = 4'hF;
	end

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		address <= a;
		writedata <= d;
		write <= 1'b1;
		do @(posedge clk); while (waitrequest !== 1'b0);
		write <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		address <= a;
		read <= 1'b1;
		do @(posedge clk); while (waitrequest !== 1'b0);
		d = readdata;
		read <= 1'b0;
		@(posedge clk);
	endtask : rd

	task automatic send(input logic [5:0] p, input logic [2:0] s, input logic [7:0] b);
		wr(OFS_FRAME, 32'h0000_0000);
		wr(OFS_PTR, 32'(p));
		wr(OFS_SUBADDR, 32'(s));
		wr(OFS_STREAM, 32'h0000_0000);
		wr(OFS_STREAM, 32'(b));
	endtask : send
endmodule : lrw_bus_model
`default_nettype wire

// *** sim/tb_lrw_addr_top.sv ***
// Self-checking bench of the display RAM write-addressing block.
// Assumes short blink and phase counts set through the parameters.
`timescale 1ns/10ps
`default_nettype none
module tb_lrw_addr_top;
	import lrw_pkg::*;
	localparam logic [2:0] HW = 3'h5;
	logic mclk;
	logic rst_n;
	logic [2:0] hw;
	logic [4:0] adr;
	logic rd_s;
	logic wr_s;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic [3:0] be;
	logic wreq;
	logic [39:0] disp;
	logic [1:0] row;
	logic ack;
	logic [31:0] d;
	int err_count;
	int cmp_count;
	int cyc;

	lrw_addr_top #(.BLINK_CYC(8), .PHASE_TICK_CYC(4)) uut (.MCLK(mclk), .RST_N(rst_n),
		.AVS_ADDRESS(adr), .AVS_READ(rd_s), .AVS_WRITE(wr_s), .AVS_WRITEDATA(wdat),
		.AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
		.HW_SUBADDR_BIT0(hw[0]), .HW_SUBADDR_BIT1(hw[1]), .HW_SUBADDR_BIT2(hw[2]),
		.DISP_DATA(disp), .DISP_ROW(row), .DATA_ACK(ack));

	lrw_bus_model bm (.clk(mclk), .address(adr), .read(rd_s), .write(wr_s),
		.writedata(wdat), .byteenable(be), .readdata(rdat), .waitrequest(wreq));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			final_report();
		end
	end

	task automatic final_report;
		$display("Checks %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report

	task automatic chk(input string n, input logic [39:0] s, input logic [39:0] e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic rchk(input string n, input logic [4:0] a, input logic [31:0] e);
		bm.rd(a, d);
		chk(n, 40'(d), 40'(e));
	endtask : rchk

	task automatic next_row(output logic [1:0] v);
		logic [1:0] p;
		int i;
		p = row;
		i = 0;
		while (row === p && i < 40) begin
			@(posedge mclk);
			i++;
		end
		v = row;
	endtask : next_row

	task automatic t_reset;
		rchk("ctrl", OFS_CTRL, 32'h0000_0000);
		rchk("ptr", OFS_PTR, 32'h0000_0000);
		rchk("subaddr", OFS_SUBADDR, 32'h0000_0000);
		rchk("status", OFS_STATUS, 32'h0000_0015);
		rchk("unmapped", 5'h18, 32'h0000_0000);
		chk("ack", 40'(ack), 40'h0);
		chk("wait idle", 40'(wreq), 40'h0);
	endtask : t_reset

	task automatic t_banks;
		bm.wr(OFS_CTRL, 32'h0000_0001);
		bm.send(6'h00, HW, 8'hFF);
		repeat (4) @(posedge mclk);
		chk("row0 data", disp, 40'h00_0000_00FF);
		bm.wr(OFS_CTRL, 32'h0000_0005);
		bm.send(6'h00, HW, 8'h0F);
		repeat (4) @(posedge mclk);
		chk("row0 kept", disp, 40'h00_0000_00FF);
		bm.wr(OFS_CTRL, 32'h0000_000D);
		repeat (4) @(posedge mclk);
		chk("alt row", 40'(row), 40'h2);
		chk("row2 data", disp, 40'h00_0000_00F0);
	endtask : t_banks

	task automatic t_mismatch;
		bm.wr(OFS_CTRL, 32'h0000_0001);
		bm.send(6'h10, 3'h6, 8'hFF);
		repeat (4) @(posedge mclk);
		chk("blocked", disp, 40'h00_0000_00FF);
		chk("no ack", 40'(ack), 40'h0);
		rchk("ptr", OFS_PTR, 32'h0000_0018);
		rchk("status", OFS_STATUS, 32'h0000_0014);
	endtask : t_mismatch

	task automatic t_cascade;
		bm.send(6'h24, 3'h4, 8'hF0);
		repeat (4) @(posedge mclk);
		chk("crossover", disp, 40'h00_0000_00F0);
		rchk("ptr wrap", OFS_PTR, 32'h0000_0004);
		rchk("counter", OFS_SUBADDR, 32'h0000_0005);
		bm.wr(OFS_CTRL, 32'h0000_0000);
		bm.send(6'h26, HW, 8'h00);
		rchk("ptr wrap", OFS_PTR, 32'h0000_0000);
		rchk("counter", OFS_SUBADDR, 32'h0000_0006);
	endtask : t_cascade

	task automatic t_steps;
		int st[4];
		st = '{2, 8, 4, 3};
		for (int m = 0; m < 4; m++) begin
			bm.wr(OFS_CTRL, 32'(m));
			bm.send(6'h00, HW, 8'hA5);
			rchk("ptr step", OFS_PTR, 32'(st[m]));
			chk("ack", 40'(ack), 40'h1);
		end
		rchk("status match", OFS_STATUS, 32'h0000_0036);
	endtask : t_steps

	task automatic t_rows;
		logic [1:0] v;
		logic [1:0] w;
		int ctl[3];
		int bs[3];
		int lst[3];
		ctl = '{0, 3, 10};
		bs = '{0, 0, 2};
		lst = '{3, 2, 1};
		for (int k = 0; k < 3; k++) begin
			bm.wr(OFS_CTRL, 32'(ctl[k]));
			next_row(v);
			next_row(v);
			repeat (4) begin
				next_row(w);
				chk("row seq", 40'(w), (v == bs[k] + lst[k]) ? 40'(bs[k]) : 40'(v + 1));
				v = w;
			end
		end
		bm.wr(OFS_CTRL, 32'h0000_0001);
		repeat (12) @(posedge mclk);
		next_row(w);
		chk("static row", 40'(w), 40'h0);
	endtask : t_rows

	task automatic t_blink;
		logic [1:0] v;
		logic [1:0] w;
		bm.wr(OFS_CTRL, 32'h0000_0011);
		next_row(v);
		next_row(w);
		chk("blink swap", 40'({v, w}), (v == 2'h2) ? 40'h8 : 40'h2);
	endtask : t_blink

	initial begin
		rst_n = 1'b0;
		hw = HW;
		err_count = 0;
		cmp_count = 0;
		cyc = 0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (6) @(posedge mclk);
		t_reset();
		t_banks();
		t_mismatch();
		t_cascade();
		t_steps();
		t_rows();
		t_blink();
		final_report();
	end
endmodule : tb_lrw_addr_top
`default_nettype wire
